// ==== inc/tfm_pkg.sv ====
// Constants shared by the telemetry frame multiplexer.
// Assumes a 100 MHz system clock and a 32-bit APB register port.
package tfm_pkg;
  // Clock and time figures
  localparam int CLK_HZ = 100_000_000;
  localparam int MAX_BIT_HZ = 80_000;
  localparam int HALF_BIT_CYCLES = CLK_HZ / (2 * MAX_BIT_HZ);
  localparam int SHIFT_PULSE_HZ = 160_000; // One pulse per half bit at top rate
  localparam int GATE_US = 75;
  localparam int GATE_HALVES = (GATE_US * (2 * MAX_BIT_HZ)) / 1_000_000;
  localparam logic [2:0] RATE_MAX_CODE = 3'h6; // 80 kbps down to 1.25 kbps

  // Frame layout
  localparam int WORD_W = 8;
  localparam int FRAME_WORDS = 128;
  localparam int FIXED_WORDS = 9;
  localparam logic [6:0] LAST_POS = 7'h7F;
  localparam logic [6:0] POS_STATUS = 7'h2F;
  localparam logic [6:0] POS_FRAME_CTR = 7'h3C;
  localparam logic [6:0] POS_PARAM_A = 7'h3D;
  localparam logic [6:0] POS_PARAM_B = 7'h3E;
  localparam logic [6:0] POS_PARAM_C = 7'h3F;
  localparam logic [6:0] POS_SUBMUX = 7'h7C;
  localparam logic [6:0] POS_SYNC0 = 7'h7D;
  localparam logic [6:0] POS_SYNC1 = 7'h7E;
  localparam logic [6:0] POS_SYNC2 = 7'h7F;
  localparam logic [7:0] SYNC0 = 8'hFA;
  localparam logic [7:0] SYNC1 = 8'hF3;
  localparam logic [7:0] SYNC2 = 8'h20;

  // Word timing in half-bit ticks
  localparam logic [3:0] HALF_LAST = 4'hF;
  localparam logic [3:0] SP_FIRST = 4'h2;
  localparam logic [3:0] SP_LAST = 4'h9;
  localparam logic [3:0] ADC_CAPTURE = 4'hE;

  // Mux address fields
  localparam int ADDR_DIGITAL = 5;
  localparam int ADDR_SUBMUX = 6;

  // Command word layout
  localparam int CMD_W = 24;
  localparam int CMD_VLOAD = 1;
  localparam int CMD_FMT_SRC = 6;
  localparam int CMD_FIXSEL_LSB = 8;
  localparam int CMD_VARSEL = 10;
  localparam int CMD_RATE_LSB = 12;
  localparam int CMD_ENC = 15;
  localparam logic [23:0] CTRL_RESET = 24'h000000;
  localparam int PIN_DATA = 0;
  localparam int PIN_CLK = 1;
  localparam int PIN_ENV = 2;

  // APB register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_VMEM = 8'h08;
  localparam logic [7:0] OFS_SWST = 8'h0C;
endpackage

// ==== hdl/tfm_telemetry_mux.sv ====
// Telemetry frame multiplexer: format-memory driven sampler and split-phase serializer.
// Assumes APB master on clk; all pins other than APB are asynchronous and synchronised here.
//
// What this block does
// - Build minor frames of 128 eight-bit words: 9 fixed, 119 variable.
// - Fixed words sit at the same positions whichever format is selected.
// - Fixed word times insert overhead content and sample no input.
// - Format memory holds 128 bytes; one location advances per word time.
// - The location value drives the multiplexer address lines.
// - Four fixed read-only formats and two variable formats, chosen by command.
// - Variable formats load over APB into the bank picked by command; fixed formats never change.
// - 32 analog, 32 digital inputs, plus submux groups in any variable position.
// - Each digital input gets word gate and shift pulses only when selected.
// - Every sample becomes one byte appended in word-slot order.
// - Bit rate selectable in power-of-two steps from 80 kbps down.
// - Serial output is split-phase PCM.
// - Convolutional encoder inserted or bypassed by command.
// - Major frame spans at most 64 minor frames.
// - 24-bit serial command moves to control at frame end after envelope.
// - Command bit picks variable format (0) or fixed format (1).
// - At top rate, eight 160 kHz shift pulses inside a 75 us gate.
`timescale 1ns/1ps
module tfm_telemetry_mux #(
  parameter int HALF_BIT_BASE = tfm_pkg::HALF_BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmdData,
  input wire logic cmdClk,
  input wire logic cmdEnv,
  input wire logic [31:0] digIn,
  input wire logic [7:0] adcResult,
  output logic adcConvert,
  output logic [7:0] muxAddr,
  output logic [4:0] submuxChan,
  output logic [31:0] wordGate,
  output logic [31:0] shiftPulse,
  output logic pcmOut
);
  import tfm_pkg::*;

  typedef struct packed {
    logic [31:0] dig1;
    logic [31:0] dig2;
    logic [2:0] cmd1;
    logic [2:0] cmd2;
    logic [2:0] cmdOld;
    logic [7:0] adc1;
    logic [7:0] adc2;
    logic [23:0] cmdShift;
    logic cmdPend;
    logic [23:0] ctrl;
    logic [23:0] swStatus;
    logic [1:0][127:0][7:0] vmem;
    logic [15:0] subCnt;
    logic [3:0] halfIdx;
    logic [6:0] pos;
    logic [5:0] frameCnt;
    logic [23:0] scTime;
    logic [7:0] txWord;
    logic [7:0] acqWord;
    logic [7:0] acqAddr;
    logic acqFixed;
    logic [1:0] enc;
    logic pcmOut;
    logic [31:0] wordGate;
    logic [31:0] shiftPulse;
    logic adcConvert;
    logic [4:0] submuxChan;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tfm_state_t;

  tfm_state_t st_reg;
  tfm_state_t st_next;
  logic [15:0] halfLen;
  logic tickEnd;
  logic wordEnd;
  logic frameEnd;
  logic curBit;
  logic sym0;
  logic sym1;

  // Fixed word positions, identical for every format
  function automatic logic isFixed(input logic [6:0] p);
    isFixed = (p == POS_STATUS) || (p >= POS_FRAME_CTR && p <= POS_PARAM_C) ||
              (p >= POS_SUBMUX);
  endfunction

  // Fixed format contents; sample table is arbitrary
  function automatic logic [7:0] romWord(input logic [1:0] f, input logic [6:0] loc);
    romWord = {2'h0, loc[0] ^ f[0], loc[5:1] ^ {4'h0, f[1]}};
  endfunction

  // Active format memory output
  function automatic logic [7:0] fmtWord(input tfm_state_t s, input logic [6:0] loc);
    if (s.ctrl[CMD_FMT_SRC]) begin
      fmtWord = romWord(s.ctrl[CMD_FIXSEL_LSB +: 2], loc);
    end else begin
      fmtWord = s.vmem[s.ctrl[CMD_VARSEL]][loc];
    end
  endfunction

  // Overhead content for fixed word positions
  function automatic logic [7:0] overhead(input tfm_state_t s, input logic [6:0] p);
    logic [23:0] grp;
    unique case (s.frameCnt[1:0])
      2'h0: grp = s.scTime;
      2'h2: grp = s.swStatus;
      default: grp = s.ctrl;
    endcase
    unique case (p)
      POS_STATUS: overhead = s.swStatus[7:0];
      POS_FRAME_CTR: overhead = {2'h0, s.frameCnt};
      POS_PARAM_A: overhead = grp[23:16];
      POS_PARAM_B: overhead = grp[15:8];
      POS_PARAM_C: overhead = grp[7:0];
      POS_SUBMUX: overhead = {2'h0, s.frameCnt};
      POS_SYNC0: overhead = SYNC0;
      POS_SYNC1: overhead = SYNC1;
      POS_SYNC2: overhead = SYNC2;
      default: overhead = 8'h00;
    endcase
  endfunction

  // Timing strobes and current serial bit
  always_comb begin
    halfLen = 16'(HALF_BIT_BASE << st_reg.ctrl[CMD_RATE_LSB +: 3]);
    tickEnd = st_reg.subCnt == 16'(halfLen - 16'h0001);
    wordEnd = tickEnd && st_reg.halfIdx == HALF_LAST;
    frameEnd = wordEnd && st_reg.pos == LAST_POS;
    curBit = st_reg.txWord[3'h7 - st_reg.halfIdx[3:1]];
    sym0 = curBit ^ st_reg.enc[0] ^ st_reg.enc[1];
    sym1 = curBit ^ st_reg.enc[1];
  end

  // Next state of the whole block
  always_comb begin
    logic [4:0] ch;
    logic [6:0] nextPos;
    logic [6:0] acqPos;
    logic secondHalf;
    logic [31:0] sel;
    ch = st_reg.acqAddr[4:0];
    nextPos = 7'(st_reg.pos + 7'h01);
    acqPos = 7'(st_reg.pos + 7'h02);
    secondHalf = st_reg.subCnt >= (halfLen >> 1);
    sel = 32'h00000001 << ch;
    st_next = st_reg;

    // Two-flop synchronisers
    st_next.dig1 = digIn;
    st_next.dig2 = st_reg.dig1;
    st_next.cmd1 = {cmdEnv, cmdClk, cmdData};
    st_next.cmd2 = st_reg.cmd1;
    st_next.cmdOld = st_reg.cmd2;
    st_next.adc1 = adcResult;
    st_next.adc2 = st_reg.adc1;

    // Serial command capture on rising command clock inside envelope
    if (st_reg.cmd2[PIN_ENV] && st_reg.cmd2[PIN_CLK] && !st_reg.cmdOld[PIN_CLK]) begin
      st_next.cmdShift = {st_reg.cmdShift[22:0], st_reg.cmd2[PIN_DATA]};
    end
    if (frameEnd && st_reg.cmdPend) begin
      st_next.ctrl = st_reg.cmdShift;
      st_next.cmdPend = 1'b0;
    end
    if (!st_reg.cmd2[PIN_ENV] && st_reg.cmdOld[PIN_ENV]) begin
      st_next.cmdPend = 1'b1; // Set wins over frame-end clear
    end

    // Half-bit tick and word counters
    st_next.subCnt = tickEnd ? 16'h0000 : 16'(st_reg.subCnt + 16'h0001);
    if (tickEnd) begin
      st_next.halfIdx = 4'(st_reg.halfIdx + 4'h1);
    end
    if (tickEnd && st_reg.halfIdx[0]) begin
      st_next.enc = {st_reg.enc[0], curBit};
    end

    // Split-phase line level, coded or plain
    if (st_reg.ctrl[CMD_ENC]) begin
      st_next.pcmOut = (st_reg.halfIdx[0] ? sym1 : sym0) ^ secondHalf;
    end else begin
      st_next.pcmOut = curBit ^ st_reg.halfIdx[0];
    end

    // Word boundary: load next byte, open acquisition for the one after
    if (wordEnd) begin
      st_next.pos = nextPos;
      st_next.txWord = st_reg.acqFixed ? overhead(st_reg, nextPos) : st_reg.acqWord;
      st_next.acqFixed = isFixed(acqPos);
      st_next.acqAddr = isFixed(acqPos) ? 8'h00 : fmtWord(st_reg, acqPos);
      st_next.acqWord = 8'h00;
      st_next.adcConvert = !isFixed(acqPos) && !fmtWord(st_reg, acqPos)[ADDR_DIGITAL];
    end else begin
      st_next.adcConvert = 1'b0;
    end
    if (frameEnd) begin
      st_next.frameCnt = 6'(st_reg.frameCnt + 6'h01);
      st_next.scTime = 24'(st_reg.scTime + 24'h000001);
    end

    // Digital source strobes, analog capture
    st_next.wordGate = 32'h00000000;
    st_next.shiftPulse = 32'h00000000;
    st_next.submuxChan = st_reg.acqAddr[ADDR_SUBMUX] ? st_reg.frameCnt[4:0] : 5'h00;
    if (!st_reg.acqFixed && st_reg.acqAddr[ADDR_DIGITAL]) begin
      if (st_reg.halfIdx < 4'(GATE_HALVES)) begin
        st_next.wordGate = sel;
      end
      if (st_reg.halfIdx >= SP_FIRST && st_reg.halfIdx <= SP_LAST) begin
        if (!secondHalf) begin
          st_next.shiftPulse = sel;
        end
        if (st_reg.subCnt == (halfLen >> 1)) begin
          st_next.acqWord = {st_reg.acqWord[6:0], st_reg.dig2[ch]};
        end
      end
    end else if (!st_reg.acqFixed && tickEnd && st_reg.halfIdx == 4'(ADC_CAPTURE - 4'h1)) begin
      st_next.acqWord = st_reg.adc2;
    end

    // APB slave: answer one cycle after setup
    st_next.pready = 1'b0;
    if (psel && !penable) begin
      st_next.pready = 1'b1;
      st_next.pslverr = 1'b0;
      unique case (paddr)
        OFS_CTRL: st_next.prdata = {8'h00, st_reg.ctrl};
        OFS_STAT: st_next.prdata = {17'h00000, st_reg.cmdPend, st_reg.frameCnt, 1'b0, st_reg.pos};
        OFS_VMEM: st_next.prdata = 32'h00000000;
        OFS_SWST: st_next.prdata = {8'h00, st_reg.swStatus};
        default: begin
          st_next.prdata = 32'h00000000;
          st_next.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st_reg.pready && pwrite) begin
      if (paddr == OFS_VMEM) begin
        st_next.vmem[st_reg.ctrl[CMD_VLOAD]][pwdata[14:8]] = pwdata[7:0];
      end
      if (paddr == OFS_SWST) begin
        st_next.swStatus = pwdata[23:0];
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.pos <= LAST_POS;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign adcConvert = st_reg.adcConvert;
  assign muxAddr = st_reg.acqAddr;
  assign submuxChan = st_reg.submuxChan;
  assign wordGate = st_reg.wordGate;
  assign shiftPulse = st_reg.shiftPulse;
  assign pcmOut = st_reg.pcmOut;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FIXED_QUIET: assert property (st_reg.acqFixed |=> wordGate == 32'h0 && shiftPulse == 32'h0)
    else $error("strobe during fixed word");
  AST_FRAME_STEP: assert property (frameEnd |=> st_reg.pos == 7'h00 &&
      st_reg.frameCnt == 6'($past(st_reg.frameCnt) + 6'h01))
    else $error("frame wrap wrong");
  AST_SYNC_WORD: assert property (wordEnd && st_reg.pos == 7'(POS_SYNC0 - 7'h01)
      |=> st_reg.txWord == SYNC0)
    else $error("sync word missing");
  AST_MUX_SOURCE: assert property (wordEnd && !isFixed(7'(st_reg.pos + 7'h02))
      |=> muxAddr == $past(fmtWord(st_reg, 7'(st_reg.pos + 7'h02))))
    else $error("mux address not from format memory");
  AST_SPLIT_PHASE: assert property (!st_reg.ctrl[CMD_ENC] && !$past(st_reg.ctrl[CMD_ENC])
      |-> pcmOut == ($past(curBit) ^ $past(st_reg.halfIdx[0])))
    else $error("split phase level wrong");
  AST_GATE_ONEHOT: assert property ($onehot0(wordGate) && (shiftPulse & ~wordGate) == 32'h0)
    else $error("strobe outside selected gate");
  AST_CMD_AT_FRAME: assert property ($changed(st_reg.ctrl) |-> $past(frameEnd))
    else $error("control changed mid frame");
  AST_APB_READY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing");

  COV_CMD_LOAD: cover property (frameEnd && st_reg.cmdPend);
  COV_DIGITAL: cover property (wordEnd && st_reg.acqAddr[ADDR_DIGITAL] && !st_reg.acqFixed);
  COV_CODED: cover property (st_reg.ctrl[CMD_ENC] && wordEnd);
  COV_VMEM_WRITE: cover property (psel && penable && pwrite && paddr == OFS_VMEM);
endmodule

// ==== sim/tfm_digital_source.sv ====
// Model of the digital data sources on the 32 serial inputs.
// Assumes gate and pulse outputs registered on clk; each source owns one byte.
`timescale 1ns/1ps
module tfm_digital_source (
  input wire logic clk,
  input wire logic rst,
  input wire logic [255:0] srcBytes,
  input wire logic [31:0] wordGate,
  input wire logic [31:0] shiftPulse,
  output logic [31:0] digIn
);
  logic [7:0] shiftReg [32];
  logic [31:0] gatePrev;
  logic [31:0] pulsePrev;

  // Load at gate rise, step at pulse end; released lines toggle
  always_ff @(posedge clk) begin
    gatePrev <= rst ? '0 : wordGate;
    pulsePrev <= rst ? '0 : shiftPulse;
    for (int i = 0; i < 32; i++) begin
      if (wordGate[i] && !gatePrev[i]) begin
        shiftReg[i] <= srcBytes[8*i +: 8];
      end else if (wordGate[i] && pulsePrev[i] && !shiftPulse[i]) begin
        shiftReg[i] <= {shiftReg[i][6:0], 1'b0};
      end
      digIn[i] <= rst ? 1'b0 : (wordGate[i] ? shiftReg[i][7] : ~digIn[i]);
    end
  end
endmodule

// ==== sim/testbench.sv ====
// Testbench: APB registers, command pins and the split-phase stream.
// Assumes half-bit base 8, so one minor frame lasts 16384 clocks.
`timescale 1ns/1ps
module testbench;
  import tfm_pkg::*;
  localparam int HB = 8;
  localparam int WRD = 16 * HB;
  localparam int FRAME = WRD * 128;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, h0, lastPcm;
  logic cmdData, cmdClk, cmdEnv, adcConvert, pcmOut, gateWas, pulseWas;
  logic measure, seen, done;
  logic [7:0] paddr, adcResult, muxAddr, b;
  logic [8:0] e;
  logic [31:0] pwdata, prdata, digIn, wordGate, shiftPulse, rd, pulseCnt, run, minRun;
  logic [4:0] submuxChan;
  logic [255:0] srcBytes;
  logic [7:0] fmt [128];
  logic [23:0] cmdWord;
  int mismatches = 0;
  int n_compared = 0;
  int cyc;
  integer seed;

  tfm_telemetry_mux #(.HALF_BIT_BASE(HB)) dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmdData(cmdData), .cmdClk(cmdClk),
    .cmdEnv(cmdEnv), .digIn(digIn), .adcResult(adcResult), .adcConvert(adcConvert),
    .muxAddr(muxAddr), .submuxChan(submuxChan), .wordGate(wordGate),
    .shiftPulse(shiftPulse), .pcmOut(pcmOut));
  tfm_digital_source src_u (.clk(clk), .rst(rst), .srcBytes(srcBytes),
    .wordGate(wordGate), .shiftPulse(shiftPulse), .digIn(digIn));

  // Clock and cycle count since reset release
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic waitc(input int n);
    while (cyc < n) @(posedge clk);
  endtask

  // Serial command at the link rate, MSB first, inside the envelope
  task automatic sendCmd(input logic [23:0] c);
    cmdEnv <= 1;
    for (int i = 23; i >= 0; i--) begin
      cmdData <= c[i];
      repeat (8) @(posedge clk);
      cmdClk <= 1;
      repeat (8) @(posedge clk);
      cmdClk <= 0;
    end
    repeat (8) @(posedge clk);
    cmdEnv <= 0;
    // Let the envelope fall pass the pin synchronisers before polling
    repeat (4) @(posedge clk);
  endtask

  // Decode one word from mid-half samples
  task automatic getWord(input int base, output logic [7:0] v);
    for (int k = 0; k < 8; k++) begin
      waitc(base + 2 * k * HB + HB / 2 + 1);
      h0 = pcmOut;
      waitc(base + (2 * k + 1) * HB + HB / 2 + 1);
      chk({31'h0, pcmOut}, {31'h0, ~h0});
      v = {v[6:0], h0};
    end
  endtask

  // Expected word of frame two; bit 8 marks words not predicted
  function automatic logic [8:0] expWord(input int w);
    logic [7:0] a;
    a = fmt[w];
    if (w == 47 || (w >= 61 && w <= 63)) return 9'h100;
    if (w == 60 || w == 124) return 9'h002;
    if (w == 125) return {1'b0, SYNC0};
    if (w == 126) return {1'b0, SYNC1};
    if (w == 127) return {1'b0, SYNC2};
    return {1'b0, a[5] ? srcBytes[8*a[4:0] +: 8] : adcResult};
  endfunction

  // Gate and pulse shape as seen by the sources
  always @(posedge clk) if (!rst) begin
    gateWas <= |wordGate;
    pulseWas <= |shiftPulse;
    if (|shiftPulse) chk(shiftPulse & ~wordGate, 0);
    if (|wordGate) chk({31'h0, $onehot(wordGate)}, 1);
    if (adcConvert) chk({26'h0, submuxChan, muxAddr[5]}, 0);
    if (|shiftPulse && !pulseWas) pulseCnt <= pulseCnt + 1;
    if (gateWas && !(|wordGate)) begin
      chk(pulseCnt, 8);
      pulseCnt <= 0;
    end
  end

  // Shortest steady stretch of the serial line while measuring
  always @(posedge clk) begin
    lastPcm <= pcmOut;
    if (!measure) begin
      run <= 0;
      seen <= 0;
      minRun <= 32'hFFFF;
    end else if (pcmOut !== lastPcm) begin
      if (seen && run < minRun) minRun <= run;
      seen <= 1;
      run <= 1;
    end else run <= run + 1;
  end

  initial begin
    seed = 32'he4020160;
    {rst, measure, psel, penable, pwrite, paddr, pwdata} = {2'b10, 43'h0};
    {cmdData, cmdClk, cmdEnv, gateWas, pulseWas, pulseCnt} = 37'h0;
    adcResult = 8'($random(seed));
    for (int i = 0; i < 8; i++) srcBytes[32*i +: 32] = $random(seed);
    repeat (12) @(posedge clk);
    rst <= 0;
    apb(0, OFS_CTRL, 0);
    chk(rd, 32'(CTRL_RESET));
    apb(1, OFS_CTRL, 32'hFFFFFF);
    apb(0, OFS_CTRL, 0);
    chk(rd, 0);
    apb(0, 8'h10, 0);
    chk({rd[31:1], err}, 1);
    apb(1, OFS_SWST, 32'h00A5C3);
    apb(0, OFS_SWST, 0);
    chk(rd, 32'h00A5C3);
    for (int i = 0; i < 128; i++) begin
      fmt[i] = {2'b00, 1'($random(seed)), 5'($random(seed))};
      apb(1, OFS_VMEM, {17'h0, 7'(i), fmt[i]});
    end
    apb(0, OFS_VMEM, 0);
    chk(rd, 0);
    for (int w = 0; w < 128; w++) begin
      getWord(FRAME + (w + 1) * WRD, b);
      e = expWord(w);
      if (e[8]) continue;
      if (w == 60 || w > 123) chk({24'h0, b}, {23'h0, e});
      else chk({24'h0, b}, {23'h0, e});
    end
    cmdWord = 24'($random(seed)) & 24'hFF0FBF | 24'h002000;
    sendCmd(cmdWord);
    apb(0, OFS_STAT, 0);
    chk({31'h0, rd[14]}, 1);
    apb(0, OFS_CTRL, 0);
    chk(rd, 0);
    done = 0;
    repeat (9000) if (!done) begin
      apb(0, OFS_STAT, 0);
      done = !rd[14];
    end
    apb(0, OFS_CTRL, 0);
    chk(rd, {8'h0, cmdWord});
    repeat (200) @(posedge clk);
    measure <= 1;
    repeat (2000) @(posedge clk);
    chk(minRun, HB << 2);
    end_of_test;
  end

  // Watchdog against a hung wait
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule
